// file: pcaur_regs.sv
/*
 register bank: converter readback, second-context results, charger control
 and usb pull-up control, reached through a generic host register port.
 assumes the spi/i2c front end gives one-cycle read and write strobes with a
 register index, all on i_clk.
*/
module pcaur_regs
	import pcaur_pkg::*;
(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	input  wire logic [pcaur_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [pcaur_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                       i_conv_done,
	input  wire logic [9:0]                 i_conv_res1,
	input  wire logic [9:0]                 i_conv_res2,
	input  wire logic                       i_hw_cur_wr,
	input  wire logic [3:0]                 i_hw_cur,
	input  wire logic                       i_hw_restart_done,
	input  wire logic                       i_hw_timer_done,
	input  wire logic                       i_auto_charging,
	input  wire logic                       i_hw_reverse_clr,
	output logic [pcaur_pkg::DATA_W-1:0]    o_rdata,
	output logic                            o_rvalid,
	output logic                            o_battery_switch_force,
	output logic                            o_battery_switch_on,
	output logic                            o_charge_fsm_restart,
	output logic                            o_charge_timer_clear,
	output logic                            o_id_pullup_source_select
);
	import pcaur_pkg::*;

	logic [DATA_W-1:0] chg_reg;
	logic [DATA_W-1:0] usb_reg;
	logic [DATA_W-1:0] rd_next;
	logic [DATA_W-1:0] wmask;
	logic              wr_chg;
	logic              wr_usb;
	pcaur_res_if       res();

	// ======================================================
	// result capture
	pcaur_res_capture u_cap (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_done (i_conv_done),
		.i_res1 (i_conv_res1),
		.i_res2 (i_conv_res2),
		.res    (res)
	);

	// ======================================================
	// write decode
	assign wr_chg = i_wr && (i_addr == IDX_CHARGER_CTRL);
	assign wr_usb = i_wr && (i_addr == IDX_USB_PULLUP);
	// while auto charging, voltage and current are locked unless overridden
	always_comb
	begin
		wmask = CHG_WR_MASK;
		if (i_auto_charging && !chg_reg[SET_OVR_B])
			wmask[6:0] = 7'h00;
	end

	// ======================================================
	// charger control register
	// hardware current load wins over a software write; a same-cycle software
	// set of bits 13, 19 or 20 beats the hardware clear so a fresh request is kept
	always_ff @(posedge i_clk or posedge i_rst)
	if (i_rst)
		chg_reg <= CHG_RESET;
	else
	begin
		if (wr_chg)
			chg_reg <= (chg_reg & ~wmask) | (i_wdata & wmask);
		if (i_hw_cur_wr)
			chg_reg[ICHG_LSB +: 4] <= i_hw_cur;
		if (i_hw_restart_done && !(wr_chg && i_wdata[FSM_RST_B]))
			chg_reg[FSM_RST_B] <= 1'b0;
		if (i_hw_timer_done && !(wr_chg && i_wdata[TMR_CLR_B]))
			chg_reg[TMR_CLR_B] <= 1'b0;
		if (i_hw_reverse_clr && !(wr_chg && i_wdata[REVERSE_B]))
			chg_reg[REVERSE_B] <= 1'b0;
	end

	// ======================================================
	// usb pull-up register
	always_ff @(posedge i_clk or posedge i_rst)
	if (i_rst)
		usb_reg <= USB_RESET;
	else if (wr_usb)
		usb_reg <= (usb_reg & ~USB_WR_MASK) | (i_wdata & USB_WR_MASK);

	// ======================================================
	// read mux, unmapped indices read zero
	always_comb
	begin
		rd_next = '0;
		unique case (i_addr)
			IDX_AUX_READBACK:
				rd_next[GEN_ID_LSB +: GEN_ID_W] = GEN_ID_DEFAULT;
			IDX_SECOND_RESULT:
			begin
				rd_next[RES1_LSB +: RES_W] = res.res1;
				rd_next[RES2_LSB +: RES_W] = res.res2;
			end
			IDX_CHARGER_CTRL:
				rd_next = chg_reg;
			IDX_USB_PULLUP:
				rd_next = usb_reg;
			default:
				rd_next = '0;
		endcase
	end

	// read data registered, one cycle after the strobe
	always_ff @(posedge i_clk or posedge i_rst)
	if (i_rst)
	begin
		o_rdata  <= '0;
		o_rvalid <= 1'b0;
	end
	else
	begin
		o_rvalid <= i_rd;
		if (i_rd)
			o_rdata <= rd_next;
	end

	// ======================================================
	// control outputs, registered from the fields; switch on is switch override ANDed with switch control
	always_ff @(posedge i_clk or posedge i_rst)
	if (i_rst)
	begin
		o_battery_switch_force    <= 1'b0;
		o_battery_switch_on       <= 1'b0;
		o_charge_fsm_restart      <= 1'b0;
		o_charge_timer_clear      <= 1'b0;
		o_id_pullup_source_select <= 1'b0;
	end
	else
	begin
		o_battery_switch_force    <= chg_reg[SW_OVR_B];
		o_battery_switch_on       <= chg_reg[SW_OVR_B] & chg_reg[SW_CTL_B];
		o_charge_fsm_restart      <= chg_reg[FSM_RST_B];
		o_charge_timer_clear      <= chg_reg[TMR_CLR_B];
		o_id_pullup_source_select <= usb_reg[ID_PU_SEL_B];
	end

	// ======================================================
	// checks
	property p_chg_reset;
		@(posedge i_clk) $fell(i_rst) |-> chg_reg[6:0] == 7'h03;
	endproperty
	a_chg_reset: assert property (p_chg_reset) else $error("bad charger reset");

	property p_switch;
		@(posedge i_clk) disable iff (i_rst)
		chg_reg[SW_OVR_B] |=> o_battery_switch_on == $past(chg_reg[SW_CTL_B]);
	endproperty
	a_switch: assert property (p_switch) else $error("switch not following");

	property p_restart;
		@(posedge i_clk) disable iff (i_rst)
		wr_chg && i_wdata[FSM_RST_B] && !i_hw_restart_done ##1 !i_hw_restart_done
		|=> o_charge_fsm_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart lost");

	property p_lock;
		@(posedge i_clk) disable iff (i_rst)
		wr_chg && i_auto_charging && !chg_reg[SET_OVR_B] && !i_hw_cur_wr
		|=> $stable(chg_reg[6:0]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked field written");

	property p_res_read;
		@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == IDX_SECOND_RESULT |=> o_rdata[1:0] == 2'h0 && o_rdata[13:12] == 2'h0;
	endproperty
	a_res_read: assert property (p_res_read) else $error("spare bits set");

	property p_res_cap;
		@(posedge i_clk) disable iff (i_rst)
		i_conv_done ##1 !i_conv_done ##1 i_rd && i_addr == IDX_SECOND_RESULT
		|=> o_rdata[11:2] == $past(i_conv_res1, 3) && o_rdata[23:14] == $past(i_conv_res2, 3);
	endproperty
	a_res_cap: assert property (p_res_cap) else $error("result not captured");

	property p_unused;
		@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == IDX_CHARGER_CTRL |=> o_rdata[14] == 1'b0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused bit set");

	property p_pullup;
		@(posedge i_clk) disable iff (i_rst)
		wr_usb ##1 1'b1 |=> o_id_pullup_source_select == $past(i_wdata[ID_PU_SEL_B], 2);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up select wrong");

	property p_cur_hw;
		@(posedge i_clk) disable iff (i_rst)
		i_hw_cur_wr |=> chg_reg[6:3] == $past(i_hw_cur);
	endproperty
	a_cur_hw: assert property (p_cur_hw) else $error("hw current lost");
endmodule

// file: pcaur_pkg.sv
/*
 holds register indices, field positions and reset values for the charger,
 converter readback and usb pull-up register slice.
 assumes a 24-bit register word and a 6-bit register index from the host port.
*/
package pcaur_pkg;
	localparam int unsigned DATA_W = 24;
	localparam int unsigned ADDR_W = 6;
	// register indices
	localparam logic [ADDR_W-1:0] IDX_AUX_READBACK  = 6'h2e;
	localparam logic [ADDR_W-1:0] IDX_SECOND_RESULT = 6'h2f;
	localparam logic [ADDR_W-1:0] IDX_CHARGER_CTRL  = 6'h30;
	localparam logic [ADDR_W-1:0] IDX_USB_PULLUP    = 6'h31;
	// readback fields
	localparam int unsigned GEN_ID_LSB = 6;
	localparam int unsigned GEN_ID_W   = 3;
	localparam int unsigned RES_W      = 10;
	localparam int unsigned RES1_LSB   = 2;
	localparam int unsigned RES2_LSB   = 14;
	// charger control fields
	localparam int unsigned VCHG_LSB   = 0;
	localparam int unsigned ICHG_LSB   = 3;
	localparam int unsigned TRICKLE_B  = 7;
	localparam int unsigned LPB_ACK_B  = 8;
	localparam int unsigned THERM_DIS_B = 9;
	localparam int unsigned SW_OVR_B   = 10;
	localparam int unsigned SW_CTL_B   = 11;
	localparam int unsigned SPARE_B    = 12;
	localparam int unsigned REVERSE_B  = 13;
	localparam int unsigned POWER_LIMIT_SETTING_LSB   = 15;
	localparam int unsigned POWER_LIMIT_SETTING_DIS_B = 17;
	localparam int unsigned IND_EN_B   = 18;
	localparam int unsigned TMR_CLR_B  = 19;
	localparam int unsigned FSM_RST_B  = 20;
	localparam int unsigned AUTO_INH_B = 21;
	localparam int unsigned CYCL_DIS_B = 22;
	localparam int unsigned SET_OVR_B  = 23;
	// usb register fields
	localparam int unsigned USB_SPARE_B  = 6;
	localparam int unsigned ID_PU_SEL_B  = 22;
	// writable masks and reset values
	localparam logic [DATA_W-1:0] CHG_WR_MASK  = 24'hffbfff;
	localparam logic [DATA_W-1:0] CHG_RESET    = 24'h400003;
	localparam logic [DATA_W-1:0] USB_WR_MASK  = 24'h400040;
	localparam logic [DATA_W-1:0] USB_RESET    = 24'h000040;
	localparam logic [GEN_ID_W-1:0] GEN_ID_DEFAULT = 3'h5; // arbitrary value
endpackage

// file: pcaur_res_if.sv
/*
 carries the second-context conversion results from the capture module
 to the register bank. assumes one clock domain.
*/
interface pcaur_res_if;
	logic [9:0] res1;
	logic [9:0] res2;
	modport src (output res1, output res2);
	modport dst (input res1, input res2);
endinterface

// file: pcaur_res_capture.sv
/*
 holds the second-context conversion results, loaded on a converter
 completion strobe. assumes the strobe and data come from same-clock logic.
*/
module pcaur_res_capture
	import pcaur_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_done,
	input  wire logic [9:0]  i_res1,
	input  wire logic [9:0]  i_res2,
	pcaur_res_if.src         res
);
	logic [9:0] res1_reg;
	logic [9:0] res2_reg;
	// ======================================================
	// result capture
	// no documented reset value; zero chosen so reads are defined
	always_ff @(posedge i_clk or posedge i_rst)
	if (i_rst)
	begin
		res1_reg <= '0;
		res2_reg <= '0;
	end
	else if (i_done)
	begin
		res1_reg <= i_res1;
		res2_reg <= i_res2;
	end
	assign res.res1 = res1_reg;
	assign res.res2 = res2_reg;
endmodule

// file: pcaur_host_model.sv
/*
 host side of the register port: one-cycle write and read strobes.
 assumes the bench calls access() and watches the design's outputs itself.
*/
module pcaur_host_model
	import pcaur_pkg::*;
(
	input  wire logic                    i_clk,
	output logic                         o_wr,
	output logic                         o_rd,
	output logic [pcaur_pkg::ADDR_W-1:0] o_addr,
	output logic [pcaur_pkg::DATA_W-1:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// port driver
	initial
	begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = '0;
		o_wdata = '0;
	end
	// after an access the address and data lines carry the inverse, so a stale value never looks valid
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
endmodule

// file: pmic_charger_adc_usb_regs_bench.sv
/*
 self-checking bench: reset values, field writes, hardware updates, capture.
 assumes pcaur_host_model drives the register port.
*/
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module pmic_charger_adc_usb_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import pcaur_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr, rd, cdone = 1'b0, hcw = 1'b0, rsd = 1'b0;
	logic tmd = 1'b0, auto = 1'b0, rvc = 1'b0, rvalid, force_o, on_o, rst_o, tmr_o, id_o;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, e;
	logic [9:0]  r1 = '0, r2 = '0;
	logic [3:0]  hc = '0;
	logic [15:0] lf = 16'h0016;
	logic [DATA_W-1:0] exp_q[$];
	int errors = 0, samples_checked = 0, cycles = 0;
	// ==========================================
	// clock, timeout, read monitor
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	// each read answer retires the oldest note
	always @(posedge clk)
		if (rvalid === 1'b1)
		begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hxxxxxx;
			`CHK("read data", e, rdata)
		end
	// ==========================================
	// instances
	pcaur_host_model u_pcaur_host_model (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
		.o_wdata(wdata));
	pcaur_regs u_pcaur_regs (.i_clk(clk), .i_rst(rst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
		.i_wdata(wdata), .i_conv_done(cdone), .i_conv_res1(r1), .i_conv_res2(r2),
		.i_hw_cur_wr(hcw), .i_hw_cur(hc), .i_hw_restart_done(rsd), .i_hw_timer_done(tmd),
		.i_auto_charging(auto), .i_hw_reverse_clr(rvc), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_battery_switch_force(force_o), .o_battery_switch_on(on_o),
		.o_charge_fsm_restart(rst_o), .o_charge_timer_clear(tmr_o),
		.o_id_pullup_source_select(id_o));
	// ==========================================
	// helpers
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic wrt(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		u_pcaur_host_model.access(1'b1, a, d);
	endtask
	task automatic rdx(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
		exp_q.push_back(x);
		u_pcaur_host_model.access(1'b0, a, 24'h0);
	endtask
	task automatic done(input string n);
		$display("test %s done", n);
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========================================
	// scenarios
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdx(IDX_CHARGER_CTRL, CHG_RESET);
		rdx(IDX_USB_PULLUP, USB_RESET);
		rdx(IDX_AUX_READBACK, 24'h000140);
		rdx(6'h00, 24'h0);
		done("reset");
		wrt(IDX_CHARGER_CTRL, 24'hffffff);
		rdx(IDX_CHARGER_CTRL, 24'hffbfff);
		`CHK("switch on", 1'b1, on_o)
		`CHK("restart", 1'b1, rst_o)
		`CHK("timer clear", 1'b1, tmr_o)
		@(posedge clk);
		{rsd, tmd, rvc} <= 3'b111;
		@(posedge clk);
		{rsd, tmd, rvc} <= 3'b000;
		rdx(IDX_CHARGER_CTRL, 24'he79fff);
		`CHK("restart", 1'b0, rst_o)
		`CHK("timer clear", 1'b0, tmr_o)
		wrt(IDX_CHARGER_CTRL, 24'h000400);
		rdx(IDX_CHARGER_CTRL, 24'h000400);
		`CHK("switch force", 1'b1, force_o)
		`CHK("switch on", 1'b0, on_o)
		done("charger fields");
		// hardware current load, then the lock while charging runs alone
		lf = lfsr_next(lf);
		@(posedge clk);
		hc <= lf[3:0];
		hcw <= 1'b1;
		@(posedge clk);
		hcw <= 1'b0;
		auto <= 1'b1;
		rdx(IDX_CHARGER_CTRL, {13'h0, 1'b1, 3'h0, lf[3:0], 3'h0});
		wrt(IDX_CHARGER_CTRL, 24'h800000);
		rdx(IDX_CHARGER_CTRL, {17'h10000, lf[3:0], 3'h0});
		wrt(IDX_CHARGER_CTRL, 24'h800005);
		rdx(IDX_CHARGER_CTRL, 24'h800005);
		auto <= 1'b0;
		done("current and lock");
		wrt(IDX_USB_PULLUP, 24'hffffff);
		rdx(IDX_USB_PULLUP, 24'h400040);
		`CHK("id pullup", 1'b1, id_o)
		wrt(IDX_USB_PULLUP, 24'h0);
		rdx(IDX_USB_PULLUP, 24'h0);
		done("usb");
		lf = lfsr_next(lf);
		@(posedge clk);
		{r2, r1} <= {lf[9:0], ~lf[15:6]};
		cdone <= 1'b1;
		@(posedge clk);
		cdone <= 1'b0;
		// read straight after the load so the capture check sees it
		rdx(IDX_SECOND_RESULT, {lf[9:0], 2'b00, ~lf[15:6], 2'b00});
		wrt(IDX_SECOND_RESULT, 24'hffffff);
		wrt(IDX_AUX_READBACK, 24'hffffff);
		rdx(IDX_SECOND_RESULT, {lf[9:0], 2'b00, ~lf[15:6], 2'b00});
		rdx(IDX_AUX_READBACK, 24'h000140);
		done("results");
		// second reset in mid-run brings the defaults back
		wrt(IDX_CHARGER_CTRL, 24'h2383f8);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdx(IDX_CHARGER_CTRL, CHG_RESET);
		repeat (3) @(posedge clk);
		`CHK("notes left", 0, exp_q.size())
		done("reset again");
		tally_and_finish();
	end
endmodule
